// ===== src/mpm_mem_pin_mux.sv
/*
 * Memory controller pin multiplexer: drives the shared pins four to
 * fourteen, the multiplexed address bus, the SRAM address latch strobe
 * and the cache output enable, in DRAM or SRAM mode.
 * Assumes all inputs are synchronous to clk and that the request
 * source waits for busy to fall before its next request.
 */
// Overview of operation
// - DRAM: pin five is bank 1 upper column strobe
// - DRAM: pins six, seven are bank 0 column strobes
// - SRAM: bank 1 transceiver enable on pins four, five
// - SRAM: bank 0 transceiver enable on pins six, seven
// - DRAM: pins eight to eleven are row strobes 3..0
// - SRAM: pins eight to eleven are chip enables 3..0
// - DRAM: pins twelve, thirteen carry byte parity
// - SRAM: pin twelve is lower output enable
// - Suspend without refresh holds every pin except the cache output enable
// - Pin fourteen selects ROM or flash select
// - Cache output enable low on cache reads
// - Core reset spares configuration
// - Row address first, then column address
`timescale 1ns/100ps
`default_nettype none
module mpm_mem_pin_mux #(
    parameter int ROW_CYC = mpm_pkg::ROW_CYCLES,
    parameter int COL_CYC = mpm_pkg::COL_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic core_reset_in,
    input wire logic suspend_status_n,
    input wire logic suspend_refresh,
    input wire logic cfg_load,
    input wire logic cfg_dram_mode,
    input wire logic cfg_pin14_flash,
    input wire logic mem_req,
    input wire logic [mpm_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [1:0] mem_bank,
    input wire logic [1:0] mem_byte_en,
    input wire logic mem_write,
    input wire logic [mpm_pkg::DATA_W-1:0] mem_wdata,
    input wire logic rom_access,
    input wire logic flash_access,
    input wire logic cache_read,
    output logic mem_busy,
    output logic dram_mode,
    output logic mem_pin_four,
    output logic mem_pin_five,
    output logic mem_pin_six,
    output logic mem_pin_seven,
    output logic mem_pin_eight,
    output logic mem_pin_nine,
    output logic mem_pin_ten,
    output logic mem_pin_eleven,
    output logic mem_pin_twelve,
    output logic mem_pin_thirteen,
    output logic mem_pin_fourteen,
    output logic [mpm_pkg::MA_W-1:0] mux_addr_bus,
    output logic sram_addr_latch_strobe,
    output logic cache_out_en_n
);
    // ----------------------------------------------------------------
    // Configuration
    // ----------------------------------------------------------------
    logic dram_q, dram_d;
    logic flash_q, flash_d;

    assign dram_d = cfg_load ? cfg_dram_mode : dram_q;
    assign flash_d = cfg_load ? cfg_pin14_flash : flash_q;
    assign dram_mode = dram_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dram_q <= mpm_pkg::CFG_DRAM_RST;
            flash_q <= mpm_pkg::CFG_FLASH_RST;
        end else begin
            dram_q <= dram_d;
            flash_q <= flash_d;
        end
    end

    // ----------------------------------------------------------------
    // Row/column sequencer
    // ----------------------------------------------------------------
    logic seq_rst;
    logic row_ph, col_ph;
    logic [mpm_pkg::MA_W-1:0] ma_next;
    logic [1:0] bank_q, be_q;
    logic wr_q;
    logic [mpm_pkg::DATA_W-1:0] wdata_q;

    assign seq_rst = !nrst || core_reset_in;

    mpm_addr_seq #(
        .ROW_CYC(ROW_CYC),
        .COL_CYC(COL_CYC)
    ) u_seq (
        .clk(clk),
        .srst(seq_rst),
        .req(mem_req),
        .addr(mem_addr),
        .bank(mem_bank),
        .byte_en(mem_byte_en),
        .write(mem_write),
        .wdata(mem_wdata),
        .busy(mem_busy),
        .phase_row(row_ph),
        .phase_col(col_ph),
        .ma(ma_next),
        .bank_q(bank_q),
        .be_q(be_q),
        .write_q(wr_q),
        .wdata_q(wdata_q)
    );

    // ----------------------------------------------------------------
    // Per-mode pin functions (all strobes active high here)
    // ----------------------------------------------------------------
    logic bank_on, active;
    logic [3:0] bank_hit;
    logic cas_h1, cas_l0, cas_h0;
    logic xcvr1, xcvr0;
    logic par_lo, par_hi;
    logic oe_lo, oe_hi;
    logic rom_sel;

    // Row strobe / chip enable stays on through the column phase
    assign active = row_ph || col_ph;
    assign bank_on = active;
    generate
        for (genvar b = 0; b < 4; b++) begin : g_bank
            assign bank_hit[b] = bank_on && (bank_q == 2'(b));
        end
    endgenerate

    assign cas_h1 = col_ph && (bank_q == mpm_pkg::BANK1) && be_q[mpm_pkg::HI_LANE];
    assign cas_l0 = col_ph && (bank_q == mpm_pkg::BANK0) && be_q[mpm_pkg::LO_LANE];
    assign cas_h0 = col_ph && (bank_q == mpm_pkg::BANK0) && be_q[mpm_pkg::HI_LANE];
    assign xcvr1 = col_ph && (bank_q == mpm_pkg::BANK1);
    assign xcvr0 = col_ph && (bank_q == mpm_pkg::BANK0);
    // Even parity per byte lane of the write data
    assign par_lo = ^wdata_q[mpm_pkg::LO_LANE*mpm_pkg::BYTE_W +: mpm_pkg::BYTE_W];
    assign par_hi = ^wdata_q[mpm_pkg::HI_LANE*mpm_pkg::BYTE_W +: mpm_pkg::BYTE_W];
    assign oe_lo = col_ph && !wr_q && be_q[mpm_pkg::LO_LANE];
    assign oe_hi = col_ph && !wr_q && be_q[mpm_pkg::HI_LANE];
    // selected chip select follows its access
    assign rom_sel = flash_q ? flash_access : rom_access;

    logic [mpm_pkg::PIN_N-1:0] pin_next;
    assign pin_next[mpm_pkg::PIN_FIVE] = dram_q ? !cas_h1 : !xcvr1;
    // SRAM bank 0 enable on both pins
    assign pin_next[mpm_pkg::PIN_SIX] = dram_q ? !cas_l0 : !xcvr0;
    assign pin_next[mpm_pkg::PIN_SEVEN] = dram_q ? !cas_h0 : !xcvr0;
    // row strobes, pin eight is bank 3
    // chip enables use the same slots
    assign pin_next[mpm_pkg::PIN_EIGHT] = !bank_hit[mpm_pkg::BANK3];
    assign pin_next[mpm_pkg::PIN_NINE] = !bank_hit[mpm_pkg::BANK2];
    assign pin_next[mpm_pkg::PIN_TEN] = !bank_hit[mpm_pkg::BANK1];
    assign pin_next[mpm_pkg::PIN_ELEVEN] = !bank_hit[mpm_pkg::BANK0];
    assign pin_next[mpm_pkg::PIN_TWELVE] = dram_q ? par_lo : !oe_lo;
    assign pin_next[mpm_pkg::PIN_THIRTEEN] = dram_q ? par_hi : !oe_hi;
    assign pin_next[mpm_pkg::PIN_FOURTEEN] = !rom_sel;

    // ----------------------------------------------------------------
    // Output keepers
    // ----------------------------------------------------------------
    logic pin_hold, ma_hold;
    logic [mpm_pkg::PIN_N-1:0] pins;
    logic [mpm_pkg::MA_W+1-1:0] ma_pack;

    assign pin_hold = !suspend_status_n && !suspend_refresh;
    // Address bus and latch strobe freeze in any suspend
    assign ma_hold = !suspend_status_n;

    mpm_pin_keeper #(
        .W(mpm_pkg::PIN_N),
        .RST(mpm_pkg::PIN_RST)
    ) u_pin_keep (
        .clk(clk),
        .nrst(nrst),
        .hold(pin_hold),
        .d(pin_next),
        .q(pins)
    );

    mpm_pin_keeper #(
        .W(mpm_pkg::MA_W + 1),
        .RST({1'h0, mpm_pkg::MA_RST})
    ) u_ma_keep (
        .clk(clk),
        .nrst(nrst),
        .hold(ma_hold),
        // latch strobe marks the SRAM row half
        .d({!dram_q && row_ph, active ? ma_next : mux_addr_bus}),
        .q(ma_pack)
    );

    assign mux_addr_bus = ma_pack[mpm_pkg::MA_W-1:0];
    assign sram_addr_latch_strobe = ma_pack[mpm_pkg::MA_W];

    // Pin four mirrors pin five in both DRAM and SRAM mode here
    assign mem_pin_four = pins[mpm_pkg::PIN_FIVE];
    assign mem_pin_five = pins[mpm_pkg::PIN_FIVE];
    assign mem_pin_six = pins[mpm_pkg::PIN_SIX];
    assign mem_pin_seven = pins[mpm_pkg::PIN_SEVEN];
    assign mem_pin_eight = pins[mpm_pkg::PIN_EIGHT];
    assign mem_pin_nine = pins[mpm_pkg::PIN_NINE];
    assign mem_pin_ten = pins[mpm_pkg::PIN_TEN];
    assign mem_pin_eleven = pins[mpm_pkg::PIN_ELEVEN];
    assign mem_pin_twelve = pins[mpm_pkg::PIN_TWELVE];
    assign mem_pin_thirteen = pins[mpm_pkg::PIN_THIRTEEN];
    assign mem_pin_fourteen = pins[mpm_pkg::PIN_FOURTEEN];

    // ----------------------------------------------------------------
    // Cache output enable
    // ----------------------------------------------------------------
    logic coe_q, coe_d;

    assign coe_d = !cache_read;
    assign cache_out_en_n = coe_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            coe_q <= 1'h1;
        end else begin
            coe_q <= coe_d;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_cas_bank1: assert property (@(posedge clk) disable iff (!nrst)
        ($past(dram_q) && !$past(pin_hold) && $past(col_ph) && $past(bank_q) == mpm_pkg::BANK1
         && $past(be_q[mpm_pkg::HI_LANE])) |-> !mem_pin_five)
        else $error("upper column strobe bank 1 missing");

    a_cas_bank0: assert property (@(posedge clk) disable iff (!nrst)
        ($past(dram_q) && !$past(pin_hold) && !$past(col_ph)) |-> (mem_pin_six && mem_pin_seven))
        else $error("bank 0 column strobe outside column phase");

    a_xcvr_dup: assert property (@(posedge clk) disable iff (!nrst)
        !$past(dram_q) |-> (mem_pin_four == mem_pin_five))
        else $error("bank 1 transceiver enable pins differ");

    a_xcvr0_dup: assert property (@(posedge clk) disable iff (!nrst)
        (!$past(dram_q) && !$past(pin_hold)) |-> (mem_pin_six == mem_pin_seven))
        else $error("bank 0 transceiver enable pins differ");

    a_row_bank: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && row_ph && bank_q == mpm_pkg::BANK3) |=> (!mem_pin_eight && mem_pin_eleven))
        else $error("row strobe on wrong pin");

    a_ce_bank0: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && !dram_q && active && bank_q == mpm_pkg::BANK0) |=> (!mem_pin_eleven && mem_pin_eight))
        else $error("bank 0 chip enable wrong");

    a_parity: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && dram_q) |=> (mem_pin_twelve == ^$past(wdata_q[mpm_pkg::BYTE_W-1:0])))
        else $error("low byte parity wrong");

    a_oe_low: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && !dram_q && col_ph && !wr_q && be_q[mpm_pkg::LO_LANE]) |=> !mem_pin_twelve)
        else $error("lower output enable not asserted");

    a_oe_high: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && !dram_q && wr_q) |=> mem_pin_thirteen)
        else $error("upper output enable on a write");

    a_suspend_hold: assert property (@(posedge clk) disable iff (!nrst)
        (pin_hold && $past(nrst)) |=> $stable(pins))
        else $error("pins moved during suspend");

    a_rom_sel: assert property (@(posedge clk) disable iff (!nrst)
        (!pin_hold && flash_q && !cfg_load && flash_access) |=> !mem_pin_fourteen)
        else $error("flash select missing");

    a_cache_oe: assert property (@(posedge clk) disable iff (!nrst)
        cache_read |=> !cache_out_en_n)
        else $error("cache output enable missing");

    a_cfg_keep: assert property (@(posedge clk) disable iff (!nrst)
        (core_reset_in && !cfg_load) |=> $stable(dram_q))
        else $error("configuration lost on core reset");

    a_row_then_col: assert property (@(posedge clk) disable iff (!nrst)
        $rose(col_ph) |-> $past(row_ph))
        else $error("column phase without row phase");
endmodule
`default_nettype wire

// ===== src/mpm_pkg.sv
/*
 * Constants shared by the memory pin multiplexer: pin slot positions,
 * field layout of the memory address, reset values and phase timing.
 * Assumes a single 50 MHz clock with a synchronous active-low reset.
 */
package mpm_pkg;
    // ----------------------------------------------------------------
    // Clock and phase timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int ROW_TIME_NS = 40;
    localparam int COL_TIME_NS = 60;
    // Least times, rounded up to whole cycles
    localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_CYCLES = (COL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // ----------------------------------------------------------------
    // Address layout: 22-bit address sent as row then column
    // ----------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int MA_W = 11;
    localparam int ROW_LSB = 11;
    localparam int COL_LSB = 0;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int LO_LANE = 0;
    localparam int HI_LANE = 1;

    // ----------------------------------------------------------------
    // Multiplexed pin slots, pins five to fourteen
    // ----------------------------------------------------------------
    localparam int PIN_N = 10;
    localparam int PIN_FIVE = 0;
    localparam int PIN_SIX = 1;
    localparam int PIN_SEVEN = 2;
    localparam int PIN_EIGHT = 3;
    localparam int PIN_NINE = 4;
    localparam int PIN_TEN = 5;
    localparam int PIN_ELEVEN = 6;
    localparam int PIN_TWELVE = 7;
    localparam int PIN_THIRTEEN = 8;
    localparam int PIN_FOURTEEN = 9;

    localparam logic [1:0] BANK0 = 2'h0;
    localparam logic [1:0] BANK1 = 2'h1;
    localparam logic [1:0] BANK2 = 2'h2;
    localparam logic [1:0] BANK3 = 2'h3;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [PIN_N-1:0] PIN_RST = 10'h3FF;
    localparam logic [MA_W-1:0] MA_RST = 11'h000;
    localparam logic CFG_DRAM_RST = 1'h1;
    localparam logic CFG_FLASH_RST = 1'h0;

    typedef enum logic [1:0] {
        MPM_IDLE,
        MPM_ROW,
        MPM_COL
    } mpm_phase_t;
endpackage

// ===== src/mpm_pin_keeper.sv
/*
 * Output holding register standing in for the pad keepers: follows its
 * input each cycle, or keeps the last level while hold is high.
 * Assumes hold and d are synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module mpm_pin_keeper #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hold,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    assign q_d = hold ? q_q : d;
    assign q = q_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            q_q <= RST;
        end else begin
            q_q <= q_d;
        end
    end
endmodule
`default_nettype wire

// ===== src/mpm_addr_seq.sv
/*
 * Row/column sequencer: takes one memory request, presents the row
 * half of the address, then the column half, and reports its phase.
 * Assumes req is only honoured while idle; srst restarts it at once.
 */
`timescale 1ns/100ps
`default_nettype none
module mpm_addr_seq #(
    parameter int ROW_CYC = mpm_pkg::ROW_CYCLES,
    parameter int COL_CYC = mpm_pkg::COL_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic req,
    input wire logic [mpm_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] bank,
    input wire logic [1:0] byte_en,
    input wire logic write,
    input wire logic [mpm_pkg::DATA_W-1:0] wdata,
    output logic busy,
    output logic phase_row,
    output logic phase_col,
    output logic [mpm_pkg::MA_W-1:0] ma,
    output logic [1:0] bank_q,
    output logic [1:0] be_q,
    output logic write_q,
    output logic [mpm_pkg::DATA_W-1:0] wdata_q
);
    mpm_pkg::mpm_phase_t state_q, state_d;
    logic [mpm_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [mpm_pkg::ADDR_W-1:0] addr_q;
    logic take;
    logic last;

    assign take = req && (state_q == mpm_pkg::MPM_IDLE);
    assign last = (cnt_q == mpm_pkg::CNT_W'(1));
    assign busy = (state_q != mpm_pkg::MPM_IDLE);
    assign phase_row = (state_q == mpm_pkg::MPM_ROW);
    assign phase_col = (state_q == mpm_pkg::MPM_COL);
    assign ma = phase_row ? addr_q[mpm_pkg::ROW_LSB +: mpm_pkg::MA_W]
                          : addr_q[mpm_pkg::COL_LSB +: mpm_pkg::MA_W];

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            mpm_pkg::MPM_IDLE: begin
                if (take) begin
                    state_d = mpm_pkg::MPM_ROW;
                    cnt_d = mpm_pkg::CNT_W'(ROW_CYC);
                end
            end
            mpm_pkg::MPM_ROW: begin
                cnt_d = cnt_q - mpm_pkg::CNT_W'(1);
                if (last) begin
                    state_d = mpm_pkg::MPM_COL;
                    cnt_d = mpm_pkg::CNT_W'(COL_CYC);
                end
            end
            mpm_pkg::MPM_COL: begin
                cnt_d = cnt_q - mpm_pkg::CNT_W'(1);
                if (last) begin
                    state_d = mpm_pkg::MPM_IDLE;
                end
            end
            default: begin
                state_d = mpm_pkg::MPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= mpm_pkg::MPM_IDLE;
            cnt_q <= '0;
            addr_q <= '0;
            bank_q <= '0;
            be_q <= '0;
            write_q <= 1'h0;
            wdata_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (take) begin
                addr_q <= addr;
                bank_q <= bank;
                be_q <= byte_en;
                write_q <= write;
                wdata_q <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/mpm_mem_model.sv
/*
 * Far-side memory model: watches the shared pins as DRAM or SRAM banks
 * with transceivers would, and records what one access presented.
 * Assumes pins are sampled on clk and that clr restarts the record.
 */
`timescale 1ns/100ps
`default_nettype none
module mpm_mem_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic dram,
    input wire logic [9:0] pins,
    input wire logic [10:0] ma,
    input wire logic latch,
    output logic [9:0] low_seen,
    output logic [10:0] row_addr,
    output logic [10:0] col_addr,
    output logic [1:0] par,
    output logic row_got,
    output logic col_got,
    output logic bad
);
    // ----------------------------------------------------------------
    // Strobe qualifiers
    // ----------------------------------------------------------------
    logic row_q;
    logic col_q;
    assign row_q = dram ? ~&pins[7:4] : latch;
    assign col_q = ~&pins[3:0];

    // ----------------------------------------------------------------
    // Capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clr) begin
            low_seen <= 10'h000;
            row_got <= 1'h0;
            col_got <= 1'h0;
            bad <= 1'h0;
        end else begin
            low_seen <= low_seen | ~pins;
            if (row_q && !row_got && !col_got) begin
                row_addr <= ma;
                row_got <= 1'h1;
            end
            // column after row, parity taken with it
            if (col_q && !col_got) begin
                col_addr <= ma;
                col_got <= 1'h1;
                par <= pins[9:8];
                if (!row_got) begin
                    bad <= 1'h1;
                end
            end
            if (!dram && (pins[0] != pins[1] || pins[2] != pins[3])) begin
                bad <= 1'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
 * Self-checking bench for the memory pin multiplexer.
 * Assumes the design's default phase lengths and a 50 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 1'h0;
    logic nrst, core_reset_in, suspend_status_n, suspend_refresh, cfg_load, cfg_dram_mode, cfg_pin14_flash;
    logic mem_req, mem_write, rom_access, flash_access, cache_read, clr, cur_dram;
    logic [21:0] mem_addr;
    logic [1:0] mem_bank, mem_byte_en, par;
    logic [15:0] mem_wdata;
    logic mem_busy, dram_mode, p4, p5, p6, p7, p8, p9, p10, p11, p12, p13, p14, latch, coe_n, row_got, col_got, bad;
    logic [10:0] mux_addr_bus, row_addr, col_addr;
    logic [9:0] low_seen;
    wire logic [9:0] pins = {p13, p12, p11, p10, p9, p8, p7, p6, p5, p4};
    int failures = 0;
    int n_compared = 0;

    always #10 clk = ~clk;

    mpm_mem_pin_mux i_mpm_mem_pin_mux (.clk(clk), .nrst(nrst), .core_reset_in(core_reset_in),
        .suspend_status_n(suspend_status_n), .suspend_refresh(suspend_refresh), .cfg_load(cfg_load),
        .cfg_dram_mode(cfg_dram_mode), .cfg_pin14_flash(cfg_pin14_flash), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_bank(mem_bank), .mem_byte_en(mem_byte_en), .mem_write(mem_write),
        .mem_wdata(mem_wdata), .rom_access(rom_access), .flash_access(flash_access),
        .cache_read(cache_read), .mem_busy(mem_busy), .dram_mode(dram_mode), .mem_pin_four(p4),
        .mem_pin_five(p5), .mem_pin_six(p6), .mem_pin_seven(p7), .mem_pin_eight(p8), .mem_pin_nine(p9),
        .mem_pin_ten(p10), .mem_pin_eleven(p11), .mem_pin_twelve(p12), .mem_pin_thirteen(p13),
        .mem_pin_fourteen(p14), .mux_addr_bus(mux_addr_bus), .sram_addr_latch_strobe(latch),
        .cache_out_en_n(coe_n));

    mpm_mem_model i_mpm_mem_model (.clk(clk), .clr(clr), .dram(cur_dram), .pins(pins), .ma(mux_addr_bus),
        .latch(latch), .low_seen(low_seen), .row_addr(row_addr), .col_addr(col_addr), .par(par),
        .row_got(row_got), .col_got(col_got), .bad(bad));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic set_cfg(input logic dm, input logic fl);
        cfg_load = 1'h1;
        cfg_dram_mode = dm;
        cfg_pin14_flash = fl;
        cur_dram = dm;
        tick(1);
        cfg_load = 1'h0;
    endtask

    task automatic start(input logic [1:0] b, input logic [1:0] be, input logic wr, input logic [21:0] a,
                         input logic [15:0] d);
        clr = 1'h1;
        tick(1);
        clr = 1'h0;
        mem_req = 1'h1;
        mem_bank = b;
        mem_byte_en = be;
        mem_write = wr;
        mem_addr = a;
        mem_wdata = d;
        tick(1);
        mem_req = 1'h0;
        chk("busy", 16'h0001, {15'h0, mem_busy});
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (mem_busy !== 1'h0 && n < 40) begin
            tick(1);
            n++;
        end
        if (n == 40) begin
            failures++;
            wrap_up();
        end
        // Pins trail the sequencer by a cycle
        tick(3);
    endtask

    task automatic one_case(input logic [1:0] b, input logic [1:0] be, input logic wr, input logic [9:0] mask,
                            input int i);
        logic [21:0] a;
        logic [15:0] d;
        logic [9:0] km;
        a = 22'h2B5C93 + 22'(i * 977);
        d = 16'h0701 + 16'(i * 4369);
        km = cur_dram ? 10'h0FF : 10'h3FF;
        start(b, be, wr, a, d);
        drain();
        chk("low pins", {6'h0, mask & km}, {6'h0, low_seen & km});
        chk("row addr", {5'h0, a[21:11]}, {5'h0, row_addr});
        if (b < 2'h2) chk("col addr", {5'h0, a[10:0]}, {5'h0, col_addr});
        if (cur_dram && b == 2'h0 && wr) chk("parity", {14'h0, ^d[15:8], ^d[7:0]}, {14'h0, par});
        chk("order", 16'h0000, {15'h0, bad});
        chk("idle pins", {6'h0, km}, {6'h0, pins & km});
        chk("latch idle", 16'h0000, {15'h0, latch});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk("reset outs", 16'h0FF5, {2'h0, pins, latch, coe_n, mem_busy, dram_mode});
        chk("reset bus", 16'h0000, {5'h0, mux_addr_bus});
        chk("reset pin14", 16'h0001, {15'h0, p14});
    endtask

    task automatic t_dram;
        one_case(2'h0, 2'h3, 1'h1, 10'h08C, 0);
        one_case(2'h0, 2'h1, 1'h1, 10'h084, 1);
        one_case(2'h0, 2'h2, 1'h0, 10'h088, 2);
        one_case(2'h1, 2'h3, 1'h1, 10'h043, 3);
        one_case(2'h2, 2'h3, 1'h0, 10'h020, 4);
        one_case(2'h3, 2'h3, 1'h1, 10'h010, 5);
    endtask

    task automatic t_sram;
        one_case(2'h0, 2'h3, 1'h0, 10'h38C, 6);
        one_case(2'h1, 2'h3, 1'h1, 10'h043, 7);
        one_case(2'h2, 2'h3, 1'h0, 10'h320, 8);
        one_case(2'h3, 2'h3, 1'h1, 10'h010, 9);
    endtask

    task automatic t_suspend;
        logic [9:0] held;
        logic [10:0] bus;
        start(2'h0, 2'h3, 1'h1, 22'h155AAA, 16'h1234);
        tick(2);
        suspend_status_n = 1'h0;
        tick(1);
        held = pins;
        bus = mux_addr_bus;
        tick(5);
        chk("held pins", {6'h0, held}, {6'h0, pins});
        chk("held bus", {5'h0, bus}, {5'h0, mux_addr_bus});
        suspend_refresh = 1'h1;
        tick(6);
        chk("refresh pins", 16'h00FF, {8'h0, pins[7:0]});
        suspend_status_n = 1'h1;
        suspend_refresh = 1'h0;
        drain();
    endtask

    task automatic t_pin14;
        set_cfg(cur_dram, 1'h0);
        rom_access = 1'h1;
        tick(2);
        chk("rom select", 16'h0000, {15'h0, p14});
        rom_access = 1'h0;
        flash_access = 1'h1;
        tick(2);
        chk("rom unselected", 16'h0001, {15'h0, p14});
        set_cfg(cur_dram, 1'h1);
        tick(1);
        chk("flash select", 16'h0000, {15'h0, p14});
        flash_access = 1'h0;
        tick(2);
        chk("flash idle", 16'h0001, {15'h0, p14});
    endtask

    task automatic t_cache;
        cache_read = 1'h1;
        tick(1);
        chk("cache oe", 16'h0000, {15'h0, coe_n});
        cache_read = 1'h0;
        tick(1);
        chk("cache oe off", 16'h0001, {15'h0, coe_n});
    endtask

    task automatic t_core_reset;
        start(2'h1, 2'h3, 1'h0, 22'h0F0F0F, 16'h0000);
        core_reset_in = 1'h1;
        tick(1);
        core_reset_in = 1'h0;
        chk("busy cleared", 16'h0000, {15'h0, mem_busy});
        chk("mode kept", 16'h0000, {15'h0, dram_mode});
        flash_access = 1'h1;
        tick(2);
        chk("flash kept", 16'h0000, {15'h0, p14});
        flash_access = 1'h0;
        tick(4);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, core_reset_in, suspend_refresh, cfg_load, cfg_pin14_flash, mem_req, mem_write} = 7'h00;
        {rom_access, flash_access, cache_read} = 3'h0;
        {suspend_status_n, cfg_dram_mode, cur_dram, clr} = 4'hF;
        mem_addr = 22'h000000;
        mem_bank = 2'h0;
        mem_byte_en = 2'h0;
        mem_wdata = 16'h0000;
        tick(10);
        nrst = 1'h1;
        tick(1);
        t_reset();
        t_dram();
        t_suspend();
        set_cfg(1'h0, 1'h0);
        t_sram();
        t_pin14();
        t_cache();
        t_core_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
